// ===== rtl/mcc_pkg.sv
// Shared constants and carrier types for the monitor conversion control core.
// Assumes a single 250 MHz core clock; all host-side strobes come from logic on that clock.
package mcc_pkg;
  localparam int CLK_MHZ          = 250;
  localparam int TEMP_PERIOD_US   = 5000;
  localparam int TEMP_PERIOD_CYC  = TEMP_PERIOD_US * CLK_MHZ;
  localparam int REF_SETTLE_US    = 60;
  localparam int REF_SETTLE_CYC   = REF_SETTLE_US * CLK_MHZ;
  localparam int DATA_W           = 12;
  localparam int NUM_TEMP         = 3;
  localparam int NUM_DAC          = 4;
  localparam int NUM_ADC          = 6;
  localparam logic [7:0] PD_RESET = 8'h30;
  localparam int PD_ADC_REF_BIT   = 4;
  localparam int PD_DAC_REF_BIT   = 5;
  localparam logic [2:0] TAG_REMOTE1 = 3'h6;
  localparam logic [2:0] TAG_REMOTE2 = 3'h7;
  localparam logic [2:0] FIRST_REMOTE_BIT = 3'h6;
  localparam logic [1:0] TIDX_REMOTE1 = 2'h0;
  localparam logic [1:0] TIDX_REMOTE2 = 2'h1;
  localparam logic [1:0] TIDX_LOCAL   = 2'h2;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b01,
    CV_BUSY = 2'b10
  } mcc_conv_e;

  typedef enum logic [2:0] {
    SRC_TEMP = 3'b001,
    SRC_HOST = 3'b010,
    SRC_AUTO = 3'b100
  } mcc_src_e;

  // One result word: channel tag and data.
  typedef struct packed {
    logic [2:0]        tag;
    logic [DATA_W-1:0] data;
  } mcc_res_s;

  // Converter selection: temp flag plus channel index.
  typedef struct packed {
    logic       temp;
    logic [2:0] chan;
  } mcc_sel_s;
endpackage

// ===== rtl/mcc_conv_ctrl.sv
// Conversion scheduler, temperature result store, overrange latches, DAC code inversion and
// reference power control. Assumes the converter answers each conv_start with one conv_done
// pulse on core_clk; sensor and comparator signals are asynchronous and are synchronised here.
//
// Overview of operation
// - Temperature inputs are refreshed in the background once every 5 ms period.
// - Finished integration raises a request; conversion starts without host action.
// - In command mode a temperature request follows the conversion in progress.
// - In autocycle a temperature request takes the next slot; the sequence continues.
// - An idle converter starts a temperature conversion at once.
// - Each of the three temperature channels keeps its last result, always readable.
// - Command mode can return stored remote temperature results in the sequence.
// - Remote results get the host's signed correction added automatically.
// - Shunt comparator above its threshold raises the channel's overrange output.
// - Undervoltage on shunt or high-side supply pin also raises overrange.
// - Overrange stays latched until the host clears it by a write.
// - Four 12-bit DAC codes are stored and inverted before the string converter.
// - Power-up selects external references; clearing two power bits enables internal ones.
// - Command write enters command mode; reads step selected channels low to high.
// - Selected remote channels start no conversion; stored result is returned instead.
// - Results carry a channel tag; remote channels are 110 and 111.
module mcc_conv_ctrl
  import mcc_pkg::*;
#(
  parameter int PERIOD_CYCLES = TEMP_PERIOD_CYC
) (
  // Clock and reset.
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  // Temperature sensor handshake.
  input  wire logic [NUM_TEMP-1:0]            integ_done,
  output logic      [NUM_TEMP-1:0]            integ_start_ff,
  // Converter.
  input  wire logic                           conv_done,
  input  wire logic [DATA_W-1:0]              conv_data,
  output logic                                conv_start_ff,
  output mcc_sel_s                            conv_sel_ff,
  // Host command and result path.
  input  wire logic                           cmd_wr,
  input  wire logic [7:0]                     cmd_byte,
  input  wire logic                           rd_strobe,
  input  wire logic                           auto_en,
  input  wire logic [NUM_ADC-1:0]             auto_mask,
  output mcc_res_s                            result_ff,
  output logic                                res_valid_ff,
  output logic                                cmd_mode_ff,
  output logic [NUM_TEMP-1:0][DATA_W-1:0]     temp_res_ff,
  // Remote temperature corrections, signed.
  input  wire logic [1:0][DATA_W-1:0]         temp_offset,
  // Current sense overrange.
  input  wire logic [1:0]                     shunt_over_cmp,
  input  wire logic [1:0]                     supply_under_cmp,
  input  wire logic [1:0]                     ovr_clr,
  output logic      [1:0]                     current_overrange_flag_ff,
  // DAC codes.
  input  wire logic                           dac_wr,
  input  wire logic [1:0]                     dac_sel,
  input  wire logic [DATA_W-1:0]              dac_code,
  output logic [NUM_DAC-1:0][DATA_W-1:0]      dac_string_ff,
  // Power-down register.
  input  wire logic                           pd_wr,
  input  wire logic [7:0]                     pd_byte,
  output logic [7:0]                          pd_ff,
  output logic                                adc_ref_on_ff,
  output logic                                dac_ref_on_ff
);

  mcc_conv_e                   state_ff;
  mcc_src_e                    src_ff;
  logic [20:0]                 per_cnt_ff;
  logic [NUM_TEMP-1:0]         done_s1_ff, done_s2_ff, done_prev_ff;
  logic [NUM_TEMP-1:0]         done_rise;
  logic [NUM_TEMP-1:0]         tpend_ff;
  logic [3:0]                  cmp_s1_ff, cmp_s2_ff;
  logic [7:0]                  cmd_ff;
  logic [2:0]                  ptr_ff;
  logic                        hreq_ff;
  logic [2:0]                  hch_ff;
  logic [2:0]                  aptr_ff;
  logic                        per_tick;
  logic                        grant;
  logic [NUM_TEMP-1:0]         tgrant;
  logic [1:0]                  tidx;
  logic                        rd_fire;
  logic                        rd_hit;
  logic [2:0]                  rd_bit;
  logic                        auto_hit;
  logic [2:0]                  auto_bit;

  // Scan from the pointer upward with wrap; first selected bit wins.
  function automatic logic [3:0] next_sel(input logic [7:0] mask, input logic [2:0] from,
                                          input int span);
    logic [3:0] r;
    int         idx;
    r = 4'h0;
    for (int k = 0; k < 8; k++) begin
      idx = (int'(from) + k) % span;
      if (k < span && !r[3] && mask[idx]) begin
        r = {1'b1, 3'(idx)};
      end
    end
    return r;
  endfunction

  assign per_tick  = (per_cnt_ff == 21'(PERIOD_CYCLES - 1));
  assign done_rise = done_s2_ff & ~done_prev_ff;
  // A read during a host conversion is refused, so a remote answer cannot mask its result.
  assign rd_fire   = rd_strobe && cmd_mode_ff && !hreq_ff
                     && !(state_ff == CV_BUSY && src_ff == SRC_HOST);
  assign {rd_hit, rd_bit}     = next_sel(cmd_ff, ptr_ff, 8);
  assign {auto_hit, auto_bit} = next_sel({2'h0, auto_mask}, aptr_ff, NUM_ADC);
  assign grant  = (state_ff == CV_IDLE);
  assign tidx   = tpend_ff[0] ? 2'h0 : (tpend_ff[1] ? 2'h1 : 2'h2);
  assign tgrant = (grant && |tpend_ff) ? NUM_TEMP'(1 << tidx) : '0;

  // Background refresh period and staggered integration starts.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_ff     <= 21'h0;
      integ_start_ff <= '0;
    end else begin
      per_cnt_ff     <= per_tick ? 21'h0 : per_cnt_ff + 21'h1;
      integ_start_ff <= {done_rise[1:0], per_tick};
    end
  end

  // Sensor and comparator synchronisers; only the second stage feeds logic.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done_s1_ff   <= '0;
      done_s2_ff   <= '0;
      done_prev_ff <= '0;
      cmp_s1_ff    <= 4'h0;
      cmp_s2_ff    <= 4'h0;
    end else begin
      done_s1_ff   <= integ_done;
      done_s2_ff   <= done_s1_ff;
      done_prev_ff <= done_s2_ff;
      cmp_s1_ff    <= {supply_under_cmp, shunt_over_cmp};
      cmp_s2_ff    <= cmp_s1_ff;
    end
  end

  // A new request wins over the grant of the same channel, so none is lost.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tpend_ff <= '0;
    end else begin
      tpend_ff <= (tpend_ff & ~tgrant) | done_rise;
    end
  end

  // Converter scheduler: temperature first, then host, then the autocycle slot.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= CV_IDLE;
      src_ff        <= SRC_TEMP;
      conv_start_ff <= 1'b0;
      conv_sel_ff   <= '0;
      aptr_ff       <= 3'h0;
    end else begin
      conv_start_ff <= 1'b0;
      case (state_ff)
        CV_IDLE: begin
          if (|tpend_ff) begin
            state_ff      <= CV_BUSY;
            src_ff        <= SRC_TEMP;
            conv_start_ff <= 1'b1;
            conv_sel_ff   <= '{temp: 1'b1, chan: {1'b0, tidx}};
          end else if (hreq_ff) begin
            state_ff      <= CV_BUSY;
            src_ff        <= SRC_HOST;
            conv_start_ff <= 1'b1;
            conv_sel_ff   <= '{temp: 1'b0, chan: hch_ff};
          end else if (auto_en && auto_hit) begin
            state_ff      <= CV_BUSY;
            src_ff        <= SRC_AUTO;
            conv_start_ff <= 1'b1;
            conv_sel_ff   <= '{temp: 1'b0, chan: auto_bit};
            aptr_ff       <= (auto_bit == 3'(NUM_ADC - 1)) ? 3'h0 : auto_bit + 3'h1;
          end
        end
        CV_BUSY: begin
          if (conv_done) begin
            state_ff <= CV_IDLE;
          end
        end
        default: begin
          state_ff <= CV_IDLE;
        end
      endcase
    end
  end

  // Command mode: write selects channels, reads step through them.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ff      <= 8'h00;
      cmd_mode_ff <= 1'b0;
      ptr_ff      <= 3'h0;
      hreq_ff     <= 1'b0;
      hch_ff      <= 3'h0;
    end else begin
      if (cmd_wr) begin
        cmd_ff      <= cmd_byte;
        cmd_mode_ff <= 1'b1;
        ptr_ff      <= 3'h0;
      end else if (auto_en) begin
        cmd_mode_ff <= 1'b0;
      end else if (rd_fire && rd_hit) begin
        ptr_ff <= rd_bit + 3'h1;
        if (rd_bit < FIRST_REMOTE_BIT) begin
          hreq_ff <= 1'b1;
          hch_ff  <= rd_bit;
        end
      end
      if (grant && !(|tpend_ff) && hreq_ff) begin
        hreq_ff <= 1'b0;
      end
    end
  end

  // Result register and temperature store.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_ff    <= '0;
      res_valid_ff <= 1'b0;
      temp_res_ff  <= '0;
    end else begin
      res_valid_ff <= 1'b0;
      if (rd_fire && rd_hit && rd_bit >= FIRST_REMOTE_BIT) begin
        // Remote channels return the stored background result, no conversion.
        res_valid_ff <= 1'b1;
        result_ff    <= '{tag: (rd_bit[0] ? TAG_REMOTE2 : TAG_REMOTE1),
                          data: temp_res_ff[rd_bit[0] ? TIDX_REMOTE2 : TIDX_REMOTE1]};
      end else if (state_ff == CV_BUSY && conv_done && src_ff != SRC_TEMP) begin
        res_valid_ff <= (src_ff == SRC_HOST);
        result_ff    <= '{tag: conv_sel_ff.chan, data: conv_data};
      end
      if (state_ff == CV_BUSY && conv_done && src_ff == SRC_TEMP) begin
        // The correction wraps in 12 bits; the host keeps it in range.
        temp_res_ff[conv_sel_ff.chan[1:0]] <= (conv_sel_ff.chan[1:0] == TIDX_LOCAL) ?
            conv_data : DATA_W'(conv_data + temp_offset[conv_sel_ff.chan[0]]);
      end
    end
  end

  // Overrange latches: a fresh trip wins over a clear in the same cycle.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      current_overrange_flag_ff <= 2'h0;
    end else begin
      current_overrange_flag_ff <= (current_overrange_flag_ff & ~ovr_clr)
                                 | cmp_s2_ff[1:0] | cmp_s2_ff[3:2];
    end
  end

  // DAC codes are stored inverted so a larger code gives a larger output.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dac_string_ff <= '{default: '1};
    end else if (dac_wr) begin
      dac_string_ff[dac_sel] <= ~dac_code;
    end
  end

  // Reference power control; settling wait is left to the host.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pd_ff         <= PD_RESET;
      adc_ref_on_ff <= 1'b0;
      dac_ref_on_ff <= 1'b0;
    end else if (pd_wr) begin
      pd_ff         <= pd_byte;
      adc_ref_on_ff <= !pd_byte[PD_ADC_REF_BIT];
      dac_ref_on_ff <= !pd_byte[PD_DAC_REF_BIT];
    end
  end

  a_ovr_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
    current_overrange_flag_ff[0] && !ovr_clr[0] |=> current_overrange_flag_ff[0])
    else $error("overrange flag dropped without a clear");

  a_ovr_trip: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(shunt_over_cmp[1]) ##1 shunt_over_cmp[1] ##1 shunt_over_cmp[1]
      |=> current_overrange_flag_ff[1])
    else $error("overrange flag not raised by comparator");

  a_dac_inverted: assert property (@(posedge core_clk) disable iff (!nrst)
    dac_wr |=> dac_string_ff[$past(dac_sel)] == ~$past(dac_code))
    else $error("dac code not inverted");

  a_ref_power: assert property (@(posedge core_clk) disable iff (!nrst)
    pd_wr |=> (adc_ref_on_ff == !$past(pd_byte[PD_ADC_REF_BIT]))
           && (dac_ref_on_ff == !$past(pd_byte[PD_DAC_REF_BIT])))
    else $error("reference enable mismatch");

  a_idle_temp_start: assert property (@(posedge core_clk) disable iff (!nrst)
    state_ff == CV_IDLE && |tpend_ff |=> conv_start_ff && conv_sel_ff.temp)
    else $error("idle converter did not start temperature conversion");

  a_temp_pend_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    tpend_ff[1] && !tgrant[1] |=> tpend_ff[1])
    else $error("temperature request lost before conversion");

  a_period_start: assert property (@(posedge core_clk) disable iff (!nrst)
    per_tick |=> integ_start_ff[0] && per_cnt_ff == 21'h0)
    else $error("period tick did not start integration");

  a_remote_tag: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_fire && rd_hit && rd_bit == 3'h7
      |=> res_valid_ff && result_ff.tag == TAG_REMOTE2 && !hreq_ff)
    else $error("remote channel read misbehaved");

  a_offset_apply: assert property (@(posedge core_clk) disable iff (!nrst)
    state_ff == CV_BUSY && conv_done && src_ff == SRC_TEMP && conv_sel_ff.chan == 3'h0
      |=> temp_res_ff[0] == DATA_W'($past(conv_data) + $past(temp_offset[0])))
    else $error("remote correction not applied");

  a_temp_after_cmd: assert property (@(posedge core_clk) disable iff (!nrst)
    state_ff == CV_BUSY && conv_done && (|tpend_ff || |done_rise)
      |=> ##[0:1] conv_start_ff && conv_sel_ff.temp)
    else $error("temperature conversion not next after current one");

  c_temp_in_cmd: cover property (@(posedge core_clk) disable iff (!nrst)
    cmd_mode_ff && src_ff == SRC_HOST && conv_done ##2 conv_start_ff && conv_sel_ff.temp);
  c_auto_insert: cover property (@(posedge core_clk) disable iff (!nrst)
    auto_en && src_ff == SRC_TEMP && conv_done ##[1:3] conv_start_ff && !conv_sel_ff.temp);
  c_ovr_clear: cover property (@(posedge core_clk) disable iff (!nrst)
    current_overrange_flag_ff[0] ##1 ovr_clr[0] ##1 !current_overrange_flag_ff[0]);

endmodule // mcc_conv_ctrl

// ===== verification/mcc_far_model.sv
// Far-side model: the temperature sensors and the converter that the core drives.
// Assumes one core_clk; all outputs change just after the rising edge.
module mcc_far_model
  import mcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                nrst,
  // Sensor handshake.
  input  wire logic [NUM_TEMP-1:0] integ_start,
  output logic      [NUM_TEMP-1:0] integ_done,
  // Converter handshake.
  input  wire logic                conv_start,
  input  wire logic                slow,
  output logic                     conv_done,
  output logic      [DATA_W-1:0]   conv_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int                integ_cnt [NUM_TEMP];
  int                conv_cnt;
  logic [DATA_W-1:0] pattern;

  // Done is a level held four cycles, so the core must catch its rising edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      integ_done <= '0;
      integ_cnt  <= '{default: 0};
    end else begin
      for (int i = 0; i < NUM_TEMP; i++) begin
        if (integ_start[i]) integ_cnt[i] <= slow ? 45 : 20;
        else if (integ_cnt[i] > 0) integ_cnt[i] <= integ_cnt[i] - 1;
        integ_done[i] <= (integ_cnt[i] > 0) && (integ_cnt[i] <= 4);
      end
    end
  end

  // Data outside the done cycle toggles, so a core that samples late sees garbage.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      conv_cnt  <= 0;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      pattern   <= 12'h5a3;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) conv_cnt <= slow ? 9 : 2;
      else if (conv_cnt > 0) conv_cnt <= conv_cnt - 1;
      if (conv_cnt == 1) begin
        conv_done <= 1'b1;
        conv_data <= pattern;
        pattern   <= {pattern[10:0], pattern[11] ^ pattern[5] ^ pattern[3] ^ pattern[0]};
      end
    end
  end
endmodule // mcc_far_model

// ===== verification/tb_monitor_conversion_control.sv
// Self-checking bench for the conversion control core with a sensor and converter model.
// Assumes the core takes strobes on the rising edge; stimulus changes on the falling edge.
module tb_monitor_conversion_control;
  import mcc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, nrst = 1'b0, slow = 1'b0;
  logic [NUM_TEMP-1:0] integ_done, integ_start;
  logic conv_done, conv_start, cmd_wr, rd_strobe, auto_en, res_valid, cmd_mode;
  logic [DATA_W-1:0] conv_data, dac_code;
  mcc_sel_s conv_sel;
  mcc_res_s result;
  logic [7:0] cmd_byte, pd_byte, pd, cmd;
  logic [NUM_ADC-1:0] auto_mask;
  logic [NUM_TEMP-1:0][DATA_W-1:0] temp_res;
  logic [1:0][DATA_W-1:0] temp_offset;
  logic [1:0] shunt_over_cmp, supply_under_cmp, ovr_clr, ovr_flag, dac_sel;
  logic dac_wr, pd_wr, adc_ref_on, dac_ref_on, t_pend1 = 0, t_pend2 = 0, auto_chk = 0;
  logic [NUM_DAC-1:0][DATA_W-1:0] dac_string;
  logic [31:0] seed = 32'h16c33e79;
  logic [2:0] tag_q[$];
  logic [2:0] tg;
  int exp_temp [NUM_TEMP] = '{default: 0};
  int exp_snap [NUM_TEMP] = '{default: 0};
  int t_idx, t_exp, last_conv, n_temp = 0, n_res = 0, n0, failures = 0, n_tests = 0;

  always #2 core_clk = ~core_clk;

  mcc_conv_ctrl #(.PERIOD_CYCLES(300)) u_dut (.core_clk(core_clk), .nrst(nrst),
    .integ_done(integ_done), .integ_start_ff(integ_start), .conv_done(conv_done),
    .conv_data(conv_data), .conv_start_ff(conv_start), .conv_sel_ff(conv_sel),
    .cmd_wr(cmd_wr), .cmd_byte(cmd_byte), .rd_strobe(rd_strobe), .auto_en(auto_en),
    .auto_mask(auto_mask), .result_ff(result), .res_valid_ff(res_valid),
    .cmd_mode_ff(cmd_mode), .temp_res_ff(temp_res), .temp_offset(temp_offset),
    .shunt_over_cmp(shunt_over_cmp), .supply_under_cmp(supply_under_cmp),
    .ovr_clr(ovr_clr), .current_overrange_flag_ff(ovr_flag), .dac_wr(dac_wr),
    .dac_sel(dac_sel), .dac_code(dac_code), .dac_string_ff(dac_string), .pd_wr(pd_wr),
    .pd_byte(pd_byte), .pd_ff(pd), .adc_ref_on_ff(adc_ref_on), .dac_ref_on_ff(dac_ref_on));

  mcc_far_model u_far (.core_clk(core_clk), .nrst(nrst), .integ_start(integ_start),
    .integ_done(integ_done), .conv_start(conv_start), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic pd_write(input logic [7:0] v);
    @(negedge core_clk) begin pd_wr = 1'b1; pd_byte = v; end
    @(negedge core_clk) pd_wr = 1'b0;
    check("ref_on", 16'({adc_ref_on, dac_ref_on}), 16'({~v[4], ~v[5]}));
  endtask

  task automatic read_one();
    int w;
    w  = 0;
    n0 = n_res;
    @(negedge core_clk) rd_strobe = 1'b1;
    @(negedge core_clk) rd_strobe = 1'b0;
    while (n_res == n0 && w < 500) begin
      @(negedge core_clk);
      w++;
    end
    check("read_answer", 16'(n_res - n0), 16'h1);
  endtask

  // Reference model of stored temperatures and of the returned result stream.
  always @(posedge core_clk) begin
    // A remote read returns the store as it stood when the strobe was taken.
    if (rd_strobe === 1'b1) exp_snap = exp_temp;
    if (t_pend2) check("temp_res", 16'(temp_res[t_idx]), 16'(t_exp));
    t_pend2 = t_pend1;
    t_pend1 = 1'b0;
    if (nrst === 1'b1 && conv_done === 1'b1) begin
      if (conv_sel.temp === 1'b1) begin
        t_idx = int'(conv_sel.chan[1:0]);
        t_exp = (t_idx == int'(TIDX_LOCAL)) ? int'(conv_data) :
                (int'(conv_data) + int'(temp_offset[t_idx])) % 4096;
        exp_temp[t_idx] = t_exp;
        t_pend1 = 1'b1;
        n_temp++;
      end else last_conv = int'(conv_data);
    end
    if (conv_start === 1'b1 && conv_sel.temp === 1'b0) begin
      check("host_chan", 16'(conv_sel.chan < 3'h6), 16'h1);
      if (auto_chk) check("auto_chan", 16'(auto_mask[conv_sel.chan]), 16'h1);
    end
    if (res_valid === 1'b1) begin
      check("res_queued", 16'(tag_q.size() > 0), 16'h1);
      tg = (tag_q.size() > 0) ? tag_q.pop_front() : 3'h0;
      check("res_tag", 16'(result.tag), 16'(tg));
      check("res_data", 16'(result.data),
            16'((tg >= 3'h6) ? exp_snap[tg - 3'h6] : last_conv));
      n_res++;
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    end_sim();
  end

  initial begin
    {cmd_wr, rd_strobe, auto_en, dac_wr, pd_wr} = '0;
    {cmd_byte, pd_byte, auto_mask, dac_sel, dac_code} = '0;
    {shunt_over_cmp, supply_under_cmp, ovr_clr} = '0;
    temp_offset = {12'(rnd()), 12'(rnd())};
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    check("pd_reset", 16'(pd), 16'(PD_RESET));
    check("ovr_reset", 16'(ovr_flag), 16'h0);
    for (int i = 0; i < NUM_DAC; i++) check("dac_reset", 16'(dac_string[i]), 16'hfff);
    for (int i = 0; i < NUM_DAC; i++) begin
      @(negedge core_clk) begin dac_wr = 1'b1; dac_sel = 2'(i); dac_code = 12'(rnd()); end
      @(negedge core_clk) dac_wr = 1'b0;
      check("dac_code", 16'(dac_string[i]), {4'h0, ~dac_code});
    end
    $display("test reset and dac done");
    pd_write(8'h10);
    pd_write(8'h20);
    pd_write(8'h30);
    pd_write(8'h00);
    repeat (REF_SETTLE_CYC) @(negedge core_clk);
    for (int k = 0; k < 4; k++) begin
      // Both fault sources on both channels: overrange, then undervoltage.
      @(negedge core_clk) if (k < 2) shunt_over_cmp[k % 2] = 1'b1;
                          else supply_under_cmp[k % 2] = 1'b1;
      repeat (4) @(negedge core_clk);
      {shunt_over_cmp, supply_under_cmp} = '0;
      repeat (6) @(negedge core_clk);
      check("ovr_latched", 16'(ovr_flag), 16'(2'b01 << (k % 2)));
      ovr_clr[k % 2] = 1'b1;
      @(negedge core_clk) ovr_clr = '0;
      @(negedge core_clk) check("ovr_cleared", 16'(ovr_flag), 16'h0);
    end
    $display("test refs and overrange done");
    n0 = n_temp;
    repeat (8) @(negedge core_clk) begin
      slow = 1'(rnd());
      repeat (300) @(negedge core_clk);
    end
    check("temp_rate", 16'(n_temp - n0 >= 18 && n_temp - n0 <= 27), 16'h1);
    $display("test background temperature done");
    cmd = 8'hc1 | (8'(rnd()) & 8'h3e);
    for (int r = 0; r < 2; r++)
      for (int b = 0; b < 8; b++) if (cmd[b]) tag_q.push_back(3'(b));
    @(negedge core_clk) begin cmd_wr = 1'b1; cmd_byte = cmd; end
    @(negedge core_clk) cmd_wr = 1'b0;
    check("cmd_mode", 16'(cmd_mode), 16'h1);
    repeat (2 * $countones(cmd)) read_one();
    check("reads_left", 16'(tag_q.size()), 16'h0);
    $display("test command mode done");
    n0 = n_temp;
    @(negedge core_clk) begin auto_mask = 6'(rnd()) | 6'h01; auto_en = 1'b1; auto_chk = 1'b1; end
    repeat (1500) @(negedge core_clk);
    check("auto_cmd_mode", 16'(cmd_mode), 16'h0);
    check("auto_temp", 16'(n_temp - n0 >= 12), 16'h1);
    auto_en = 1'b0;
    auto_chk = 1'b0;
    // Outside command mode a read strobe must be ignored.
    n0 = n_res;
    @(negedge core_clk) rd_strobe = 1'b1;
    @(negedge core_clk) rd_strobe = 1'b0;
    repeat (20) @(negedge core_clk);
    check("read_refused", 16'(n_res - n0), 16'h0);
    $display("test autocycle done");
    end_sim();
  end
endmodule // tb_monitor_conversion_control
